// file: verilog/timer_zero_pkg.sv
// constants and types for the timer zero block
`default_nettype none
package timer_zero_pkg;
	// ********************************
	// register indices and byte addresses
	// ********************************
	localparam logic [7:0] IDX_COUNT  = 8'h01;
	localparam logic [7:0] IDX_INTCTL = 8'h0B;
	localparam logic [7:0] IDX_OPTION = 8'h81;
	localparam int         IDX_SHIFT  = 2;

	// ********************************
	// field positions and reset values
	// ********************************
	localparam int         OPT_SRC    = 5;
	localparam int         OPT_EDGE   = 4;
	localparam int         OPT_ASSIGN = 3;
	localparam int         OPT_RATE   = 0;
	localparam int         RATE_W     = 3;
	localparam int         INT_IE     = 5;
	localparam int         INT_FLAG   = 2;
	localparam logic [7:0] OPTION_RST = 8'hFF;
	localparam logic [7:0] COUNT_RST  = 8'h00;
	localparam logic [7:0] COUNT_MAX  = 8'hFF;
	localparam logic [7:0] ZERO8      = 8'h00;

	// ********************************
	// timing
	// ********************************
	localparam int         CLK_HZ      = 20_000_000;
	localparam int         INHIBIT_W   = 2;
	localparam logic [1:0] INHIBIT_CYC = 2'h2;

	// ********************************
	// bus answers and types
	// ********************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// phase clocks, gray coded
	typedef enum logic [1:0] {
		PH_FIRST  = 2'h0,
		PH_SECOND = 2'h1,
		PH_THIRD  = 2'h3,
		PH_FOURTH = 2'h2
	} phase_t;

	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_COUNT,
		SEL_INTCTL,
		SEL_OPTION
	} sel_t;
endpackage : timer_zero_pkg
`default_nettype wire

// file: verilog/shared_prescaler.sv
// shared prescaler serving the timer or the watchdog
`timescale 1ns/1ps
`default_nettype none
module shared_prescaler #(
	parameter int WIDTH  = 8,
	parameter int RATE_W = 3
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// control
	input  wire logic              tick_in,
	input  wire logic              clear,
	input  wire logic              to_watchdog,
	input  wire logic [RATE_W-1:0] rate,
	// outputs
	output logic                   timer_level,
	output logic                   watchdog_pulse
);
	// refuse a counter too short for the highest rate code
	if (WIDTH < (1 << RATE_W)) begin : g_width_check
		$error("prescaler narrower than rate range");
	end

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;
	logic [WIDTH-1:0] wd_mask;

	// low-ones mask for the watchdog ratio
	function automatic logic [WIDTH-1:0] ones_below(input logic [RATE_W-1:0] r);
		logic [WIDTH-1:0] m;
		m = '0;
		for (int i = 0; i < WIDTH; i++) begin
			if (i < int'(r))
				m[i] = 1'b1;
		end
		return m;
	endfunction : ones_below

	// count is never visible to software
	assign count_nxt = clear ? '0 : (tick_in ? count_r + 1'b1 : count_r);
	assign wd_mask = ones_below(rate);
	// timer ratio 1:2 to 1:256, watchdog 1:1 to 1:128
	assign timer_level = count_r[rate];
	assign watchdog_pulse = to_watchdog & tick_in & ((count_r & wd_mask) == wd_mask);

	// counter
	always_ff @(posedge aclk) begin
		if (!aresetn)
			count_r <= '0;
		else
			count_r <= count_nxt;
	end
endmodule : shared_prescaler
`default_nettype wire

// file: verilog/timer_zero.sv
// timer zero with shared prescaler and register slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - source select clear: count one per instruction cycle without prescaler
// - after a count write, increments held off for two instruction cycles
// - source select set: count transitions of the external input
// - edge select 1 counts falling edges, 0 counts rising edges
// - rollover from FFh to 00h sets the overflow flag
// - interrupt request raised only while enable set; mask leaves flag
// - flag held until software clears it; hardware never clears it
// - timer stops in sleep; no overflow or wake in sleep
// - prescaler output sampled on second and fourth phase clocks
// - one prescaler serves timer or watchdog, the other runs without
// - prescaler count is not readable or writable by software
// - assign bit 1 gives prescaler to watchdog, 0 to timer
// - rate codes give 1:2..1:256 timer, 1:1..1:128 watchdog
// - count write clears prescaler when timer owns it; assignment kept
// - watchdog clear instruction clears prescaler when watchdog owns it
// - count is 8-bit read/write, untouched by non-power resets
module timer_zero #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// write address channel
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// write data channel
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// write response channel
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// read address channel
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// read data channel
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// counter pin
	input  wire logic              external_count_input,
	// core and watchdog side
	input  wire logic              sleep_active,
	input  wire logic              watchdog_clear_instruction,
	input  wire logic              watchdog_raw_tick,
	output logic                   watchdog_tick,
	output logic                   overflow_irq
);
	// refuse an address bus that cannot reach the option register
	if (ADDR_W < 8 + timer_zero_pkg::IDX_SHIFT + 1) begin : g_addr_check
		$error("address too narrow for register map");
	end

	// ********************************
	// address decode
	// ********************************
	localparam int IW = ADDR_W - timer_zero_pkg::IDX_SHIFT;

	function automatic timer_zero_pkg::sel_t decode(input logic [ADDR_W-1:0] a);
		logic [IW-1:0] idx;
		idx = a[ADDR_W-1:timer_zero_pkg::IDX_SHIFT];
		if (idx == IW'(timer_zero_pkg::IDX_COUNT))
			return timer_zero_pkg::SEL_COUNT;
		else if (idx == IW'(timer_zero_pkg::IDX_INTCTL))
			return timer_zero_pkg::SEL_INTCTL;
		else if (idx == IW'(timer_zero_pkg::IDX_OPTION))
			return timer_zero_pkg::SEL_OPTION;
		else
			return timer_zero_pkg::SEL_NONE;
	endfunction : decode

	// ********************************
	// state
	// ********************************
	timer_zero_pkg::phase_t phase_r;
	timer_zero_pkg::phase_t phase_nxt;
	logic [7:0]   count_r;
	logic [7:0]   option_r;
	logic         flag_r;
	logic         flag_nxt;
	logic         irq_en_r;
	logic         irq_r;
	logic [timer_zero_pkg::INHIBIT_W-1:0] inhibit_r;
	logic         pin_meta_r;
	logic         pin_sync_r;
	logic         pin_prev_r;
	logic         sampled_r;
	logic         wd_out_r;
	// bus registers
	logic              aw_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic              w_held_r;
	logic [7:0]        w_data_r;
	logic              w_lane0_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;

	// ********************************
	// phase clocks
	// ********************************
	always_comb begin
		unique case (phase_r)
			timer_zero_pkg::PH_FIRST:  phase_nxt = timer_zero_pkg::PH_SECOND;
			timer_zero_pkg::PH_SECOND: phase_nxt = timer_zero_pkg::PH_THIRD;
			timer_zero_pkg::PH_THIRD:  phase_nxt = timer_zero_pkg::PH_FOURTH;
			timer_zero_pkg::PH_FOURTH: phase_nxt = timer_zero_pkg::PH_FIRST;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			phase_r <= timer_zero_pkg::PH_FIRST;
		else
			phase_r <= phase_nxt;
	end

	// instruction cycle ends on the fourth phase
	wire instr_pulse = (phase_r == timer_zero_pkg::PH_FOURTH);
	wire sample_en = (phase_r == timer_zero_pkg::PH_SECOND) | instr_pulse;

	// ********************************
	// option fields
	// ********************************
	wire       src_ext   = option_r[timer_zero_pkg::OPT_SRC];
	wire       edge_fall = option_r[timer_zero_pkg::OPT_EDGE];
	wire       to_wd     = option_r[timer_zero_pkg::OPT_ASSIGN];
	wire [2:0] rate      = option_r[timer_zero_pkg::OPT_RATE +: timer_zero_pkg::RATE_W];

	// ********************************
	// bus write decode
	// ********************************
	wire do_write = aw_held_r & w_held_r & ~bvalid_r;
	timer_zero_pkg::sel_t wr_sel;
	assign wr_sel = decode(aw_addr_r);
	wire wr_count  = do_write & w_lane0_r & (wr_sel == timer_zero_pkg::SEL_COUNT);
	wire wr_intctl = do_write & w_lane0_r & (wr_sel == timer_zero_pkg::SEL_INTCTL);
	wire wr_option = do_write & w_lane0_r & (wr_sel == timer_zero_pkg::SEL_OPTION);
	wire wr_hit    = (wr_sel != timer_zero_pkg::SEL_NONE);

	// ********************************
	// external input path
	// ********************************
	// counted edge becomes a rising edge of pin_level
	wire pin_level = pin_sync_r ^ edge_fall;
	wire ext_edge  = pin_level & ~pin_prev_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
			pin_prev_r <= timer_zero_pkg::OPTION_RST[timer_zero_pkg::OPT_EDGE]; // idle low pin, no false edge
		end else begin
			pin_meta_r <= external_count_input;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_level;
		end
	end

	// ********************************
	// shared prescaler
	// ********************************
	// timer side halts in sleep, watchdog side keeps going
	wire timer_src   = src_ext ? ext_edge : instr_pulse;
	wire presc_tick  = to_wd ? watchdog_raw_tick : (timer_src & ~sleep_active);
	wire presc_clear = to_wd ? watchdog_clear_instruction : wr_count;
	wire presc_level;
	wire presc_wd_pulse;

	shared_prescaler #(
		.WIDTH  (8),
		.RATE_W (timer_zero_pkg::RATE_W)
	) shared_prescaler_inst (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.tick_in        (presc_tick),
		.clear          (presc_clear),
		.to_watchdog    (to_wd),
		.rate           (rate),
		.timer_level    (presc_level),
		.watchdog_pulse (presc_wd_pulse)
	);

	// watchdog gets raw tick when it does not own the prescaler
	always_ff @(posedge aclk) begin
		if (!aresetn)
			wd_out_r <= 1'b0;
		else
			wd_out_r <= to_wd ? presc_wd_pulse : watchdog_raw_tick;
	end

	// ********************************
	// increment decision
	// ********************************
	// with no prescaler the pin itself is the prescaler output
	wire src_level = (src_ext & to_wd) ? pin_level : presc_level;
	wire samp_rise = sample_en & src_level & ~sampled_r;
	wire inc_req   = (~src_ext & to_wd) ? instr_pulse : samp_rise;
	wire inhibit   = (inhibit_r != '0);
	wire inc       = inc_req & ~sleep_active & ~inhibit & ~wr_count;
	wire overflow  = inc & (count_r == timer_zero_pkg::COUNT_MAX);

	always_ff @(posedge aclk) begin
		// matches the idle source level under the reset edge select
		if (!aresetn)
			sampled_r <= timer_zero_pkg::OPTION_RST[timer_zero_pkg::OPT_EDGE];
		else if (sample_en)
			sampled_r <= src_level;
	end

	// holdoff counts down over instruction cycles
	always_ff @(posedge aclk) begin
		if (!aresetn)
			inhibit_r <= '0;
		else if (wr_count)
			inhibit_r <= timer_zero_pkg::INHIBIT_CYC;
		else if (instr_pulse && inhibit)
			inhibit_r <= inhibit_r - 1'b1;
	end

	// ********************************
	// count register
	// ********************************
	always_ff @(posedge aclk) begin
		if (!aresetn)
			count_r <= timer_zero_pkg::COUNT_RST;
		else if (wr_count)
			count_r <= w_data_r;
		else if (inc)
			count_r <= count_r + 1'b1;
	end

	// ********************************
	// flag, enable and request
	// ********************************
	// set beats a software clear in the same cycle
	assign flag_nxt = overflow ? 1'b1 :
		(wr_intctl ? w_data_r[timer_zero_pkg::INT_FLAG] : flag_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_r   <= 1'b0;
			irq_en_r <= 1'b0;
			irq_r    <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			if (wr_intctl)
				irq_en_r <= w_data_r[timer_zero_pkg::INT_IE];
			irq_r <= flag_r & irq_en_r;
		end
	end

	// ********************************
	// option register
	// ********************************
	always_ff @(posedge aclk) begin
		if (!aresetn)
			option_r <= timer_zero_pkg::OPTION_RST;
		else if (wr_option)
			option_r <= w_data_r;
	end

	// ********************************
	// bus write channels
	// ********************************
	assign s_axi_awready = ~aw_held_r & ~bvalid_r;
	assign s_axi_wready  = ~w_held_r & ~bvalid_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_held_r  <= 1'b0;
			w_data_r  <= timer_zero_pkg::ZERO8;
			w_lane0_r <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= timer_zero_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r  <= 1'b1;
				w_data_r  <= s_axi_wdata[7:0];
				w_lane0_r <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_hit ? timer_zero_pkg::RESP_OKAY : timer_zero_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	// ********************************
	// bus read channels
	// ********************************
	timer_zero_pkg::sel_t rd_sel;
	assign rd_sel = decode(s_axi_araddr);
	wire [7:0] intctl_view = (8'(irq_en_r) << timer_zero_pkg::INT_IE)
		| (8'(flag_r) << timer_zero_pkg::INT_FLAG);
	// prescaler count has no read path
	wire [7:0] rd_byte = (rd_sel == timer_zero_pkg::SEL_COUNT)  ? count_r :
		(rd_sel == timer_zero_pkg::SEL_INTCTL) ? intctl_view :
		(rd_sel == timer_zero_pkg::SEL_OPTION) ? option_r : timer_zero_pkg::ZERO8;
	wire ar_take = s_axi_arvalid & ~rvalid_r;

	assign s_axi_arready = ~rvalid_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= timer_zero_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= {24'h000000, rd_byte};
			rresp_r  <= (rd_sel == timer_zero_pkg::SEL_NONE) ?
				timer_zero_pkg::RESP_SLVERR : timer_zero_pkg::RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign overflow_irq  = irq_r;
	assign watchdog_tick = wd_out_r;
endmodule : timer_zero
`default_nettype wire

// file: dv/timer_zero_checker.sv
// port checker for the timer zero block
`timescale 1ns/1ps
`default_nettype none
module timer_zero_checker (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// core and watchdog side
	input wire logic        sleep_active,
	input wire logic        watchdog_raw_tick,
	input wire logic        watchdog_tick,
	input wire logic        overflow_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [4:0] quiet_r;

	// cycles of sleep with no register write in flight
	always_ff @(posedge aclk) begin
		if (!aresetn || !sleep_active || s_axi_bvalid)
			quiet_r <= 5'h00;
		else if (quiet_r != 5'h1F)
			quiet_r <= quiet_r + 5'h01;
	end

	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer not held");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not held");
	a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_resp_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data above bit 7");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == timer_zero_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("refused read returned data");
	a_tick_source: assert property (watchdog_tick |-> $past(watchdog_raw_tick))
		else $error("watchdog tick without raw tick");
	a_sleep_quiet: assert property (quiet_r >= 5'h10 |-> !$rose(overflow_irq))
		else $error("overflow request in sleep");

	c_irq: cover property ($rose(overflow_irq));
	c_tick: cover property (watchdog_tick);
	c_refused: cover property (s_axi_rvalid && s_axi_rresp == timer_zero_pkg::RESP_SLVERR);
endmodule : timer_zero_checker

bind timer_zero timer_zero_checker timer_zero_checker_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_active, .watchdog_raw_tick,
	.watchdog_tick, .overflow_irq);
`default_nettype wire

// file: dv/count_pulse_source.sv
// pulse source on the external counter pin
`timescale 1ns/1ps
`default_nettype none
module count_pulse_source (
	// clock
	input  wire logic aclk,
	// counter pin
	output logic      pin
);
	initial pin = 1'b0;

	// n rising edges, each level held two cycles, line left high
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk) pin <= 1'b1;
			@(posedge aclk);
			if (i < n - 1) begin
				@(posedge aclk) pin <= 1'b0;
				@(posedge aclk);
			end
		end
	endtask : pulses

	// back to the idle low level
	task automatic idle();
		@(posedge aclk) pin <= 1'b0;
		@(posedge aclk);
	endtask : idle
endmodule : count_pulse_source
`default_nettype wire

// file: dv/timer_zero_bench.sv
// self-checking bench for the timer zero block
`timescale 1ns/1ps
`default_nettype none
module timer_zero_bench;
	localparam logic [11:0] A_CNT = {2'h0, timer_zero_pkg::IDX_COUNT, 2'h0};
	localparam logic [11:0] A_INT = {2'h0, timer_zero_pkg::IDX_INTCTL, 2'h0};
	localparam logic [11:0] A_OPT = {2'h0, timer_zero_pkg::IDX_OPTION, 2'h0};
	localparam logic [1:0]  OK    = timer_zero_pkg::RESP_OKAY;
	localparam logic [1:0]  ERR   = timer_zero_pkg::RESP_SLVERR;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, ext_pin;
	logic        sleep_on, wdog_clr, wdog_raw, wdog_tick, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [7:0]  v1, v2;
	int          n_mismatch, n_checks, cyc, ticks, t, w;

	// ********************************
	// clock, cycle and tick counters
	// ********************************
	initial aclk = 1'b0;
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (wdog_tick) ticks <= ticks + 1;
	end

	timer_zero #(.ADDR_W(12)) timer_zero_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.external_count_input(ext_pin), .sleep_active(sleep_on), .watchdog_clear_instruction(wdog_clr),
		.watchdog_raw_tick(wdog_raw), .watchdog_tick(wdog_tick), .overflow_irq(irq));
	count_pulse_source count_pulse_source_inst (.aclk(aclk), .pin(ext_pin));

	// ********************************
	// tasks
	// ********************************
	task automatic end_of_test();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check

	task automatic limit(input int k);
		if (k >= 200) begin
			n_mismatch++;
			end_of_test();
		end
	endtask : limit

	// one bus write, address and data offered together
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = OK);
		int k;
		k = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && k < 200);
		check(bresp, er);
		bready <= 1'b0;
		limit(k);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [7:0] d, input logic [1:0] er = OK);
		int k;
		k = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			k++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && k < 200);
		d = rdata[7:0];
		check(rresp, er);
		rready <= 1'b0;
		limit(k);
	endtask : rd

	task automatic rc(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = OK);
		logic [7:0] d;
		rd(a, d, er);
		check(d, e);
	endtask : rc

	task automatic upto(input int target);
		while (cyc < target) @(posedge aclk);
	endtask : upto

	// read issued a fixed offset after the target cycle
	task automatic rd_at(input logic [11:0] a, input int target, output logic [7:0] d);
		upto(target);
		rd(a, d);
	endtask : rd_at

	task automatic raw(input int n);
		repeat (n) begin
			@(posedge aclk) wdog_raw <= 1'b1;
			@(posedge aclk) wdog_raw <= 1'b0;
		end
	endtask : raw

	task automatic clr_wd();
		@(posedge aclk) wdog_clr <= 1'b1;
		@(posedge aclk) wdog_clr <= 1'b0;
	endtask : clr_wd

	// ********************************
	// main sequence
	// ********************************
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_on, wdog_clr, wdog_raw} = '0;
		{awaddr, araddr, wdata} = '0;
		{n_mismatch, n_checks, cyc, ticks} = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, register access, unmapped places
		rc(A_OPT, 8'hFF);
		rc(A_INT, 8'h00);
		rc(A_CNT, 8'h00);
		rc(12'h008, 8'h00, ERR);
		wr(12'h00C, 8'h55, ERR);
		wr(A_OPT, 8'hC8);
		rc(A_OPT, 8'hC8);
		wr(A_INT, 8'hFF);
		@(posedge aclk);
		check(irq, 1'b1);
		rc(A_INT, 8'h24);
		wr(A_INT, 8'h00);
		// count load and increment hold-off
		t = cyc + 8;
		upto(t);
		wr(A_CNT, 8'h40);
		rd_at(A_CNT, t + 40, v1);
		check((v1 == 8'h47) || (v1 == 8'h48), 1'b1);
		// overflow, flag, mask, continued counting
		wr(A_CNT, 8'hFE);
		repeat (40) @(posedge aclk);
		check(irq, 1'b0);
		rc(A_INT, 8'h04);
		t = cyc + 4;
		rd_at(A_CNT, t, v1);
		rd_at(A_CNT, t + 40, v2);
		check(v1 < 8'h20, 1'b1);
		check(v2 - v1, 8'h0A);
		wr(A_INT, 8'h24);
		@(posedge aclk);
		check(irq, 1'b1);
		wr(A_INT, 8'h04);
		@(posedge aclk);
		check(irq, 1'b0);
		repeat (400) @(posedge aclk);
		rc(A_INT, 8'h04);
		wr(A_INT, 8'h00);
		rc(A_INT, 8'h00);
		// sleep freezes the count just short of rollover, request enabled
		wr(A_INT, 8'h20);
		wr(A_CNT, 8'hF0);
		sleep_on <= 1'b1;
		t = cyc + 8;
		rd_at(A_CNT, t, v1);
		rd_at(A_CNT, t + 80, v2);
		check(v1, 8'hF0);
		check(v2, v1);
		rc(A_INT, 8'h20);
		sleep_on <= 1'b0;
		// timer-owned prescaler at every rate, watchdog unscaled
		for (int r = 0; r < 8; r++) begin
			wr(A_OPT, {5'h00, r[2:0]});
			wr(A_CNT, 8'h00);
			rc(A_OPT, {5'h00, r[2:0]});
			t = cyc + 4;
			rd_at(A_CNT, t, v1);
			rd_at(A_CNT, t + (16 << r), v2);
			check(v2 - v1, 8'h02);
			w = ticks;
			raw(3);
			repeat (2) @(posedge aclk);
			check(ticks - w, 3);
		end
		// count writes clear the prescaler before it fills
		repeat (5) begin
			repeat (300) @(posedge aclk);
			wr(A_CNT, 8'h00);
		end
		rc(A_CNT, 8'h00);
		// watchdog-owned prescaler, cleared mid-count
		wr(A_CNT, 8'h00);
		clr_wd();
		for (int r = 0; r < 8; r++) begin
			wr(A_OPT, {5'h01, r[2:0]});
			raw((1 << r) - 1);
			clr_wd();
			w = ticks;
			raw((1 << r) - 1);
			repeat (2) @(posedge aclk);
			check(ticks - w, 0);
			raw(1);
			repeat (2) @(posedge aclk);
			check(ticks - w, 1);
		end
		// external pin counting on each edge polarity
		for (int e = 0; e < 2; e++) begin
			wr(A_OPT, {2'h0, 1'b1, e[0], 4'h8});
			wr(A_CNT, 8'h00);
			repeat (12) @(posedge aclk);
			count_pulse_source_inst.pulses(5);
			repeat (8) @(posedge aclk);
			rc(A_CNT, (e == 1) ? 8'h04 : 8'h05);
			count_pulse_source_inst.idle();
			repeat (8) @(posedge aclk);
			rc(A_CNT, 8'h05);
		end
		end_of_test();
	end
endmodule : timer_zero_bench
`default_nettype wire
